// [shared/wpt_pkg.sv]
/*
  constants shared by the watchdog / periodic timer block: register offsets,
  field positions, reset values and counter figures.
  assumes a byte-addressed 8-bit register offset and 16-bit register data.
*/
package wpt_pkg;

  // ==========================================================================
  // register offsets
  localparam logic [7:0] WPT_OFF_CONFIG = 8'h00;
  localparam logic [7:0] WPT_OFF_PROT   = 8'h21;
  localparam logic [7:0] WPT_OFF_PCTRL  = 8'h22;
  localparam logic [7:0] WPT_OFF_PMOD   = 8'h24;
  localparam logic [7:0] WPT_OFF_SVC    = 8'h27;

  // ==========================================================================
  // field positions
  localparam int WPT_CFG_FREEZE_BIT = 14;
  localparam int WPT_PROT_EN_BIT    = 7;
  localparam int WPT_PROT_PRE_BIT   = 6;
  localparam int WPT_PROT_TIM_LSB   = 4;
  localparam int WPT_PCTRL_LVL_LSB  = 8;
  localparam int WPT_PMOD_PRE_BIT   = 8;

  // ==========================================================================
  // reset values
  localparam logic       WPT_RST_WD_EN  = 1'b1;
  localparam logic [1:0] WPT_RST_WD_TIM = 2'h0;
  localparam logic [2:0] WPT_RST_LVL    = 3'h0;
  localparam logic [7:0] WPT_RST_VECTOR = 8'h0f;
  localparam logic [7:0] WPT_RST_MOD    = 8'h00;

  // ==========================================================================
  // service sequence and counting figures
  localparam logic [7:0] WPT_SVC_ARM    = 8'h55;
  localparam logic [7:0] WPT_SVC_FIRE   = 8'haa;
  localparam int         WPT_PRESCALE   = 512;
  localparam int         WPT_REF_DIV    = 4;
  localparam int         WPT_WD_EXP_MIN = 9;
  localparam int         WPT_WD_EXP_STP = 2;
  localparam logic [1:0] WPT_STRAP_AT   = 2'h2;

endpackage

// [hdl/wpt_div512.sv]
/*
  divide-by-512 tick prescaler with bypass.
  assumes tick_in is a one-cycle pulse on the same clock.
*/
`timescale 1ns/1ps
module wpt_div512 (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic tick_in,
  input  wire logic bypass,
  output logic      tick_out
);
  import wpt_pkg::*;

  typedef struct packed {
    logic [8:0] cnt;
  } wpt_div_st_t;

  wpt_div_st_t st_q;
  wpt_div_st_t st_d;

  localparam logic [8:0] LAST = 9'(WPT_PRESCALE - 1);

  // ==========================================================================
  // prescaler
  always_comb begin
    st_d     = st_q;
    tick_out = tick_in & (bypass | (st_q.cnt == LAST));
    if (tick_in && !bypass) begin
      st_d.cnt = st_q.cnt + 9'h001;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule

// [hdl/wpt_svc_seq.sv]
/*
  watchdog service sequence detector: arm byte, then fire byte.
  assumes wr is a one-cycle write strobe already decoded to the service register.
*/
`timescale 1ns/1ps
module wpt_svc_seq (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       wr,
  input  wire logic [7:0] wdata,
  output logic            done
);
  import wpt_pkg::*;

  typedef enum logic [1:0] {
    SVC_IDLE  = 2'b01,
    SVC_ARMED = 2'b10
  } wpt_svc_state_t;

  typedef struct packed {
    wpt_svc_state_t state;
  } wpt_svc_st_t;

  wpt_svc_st_t st_q;
  wpt_svc_st_t st_d;

  // ==========================================================================
  // sequence; unrelated writes leave the armed state alone
  always_comb begin
    st_d = st_q;
    done = 1'b0;
    unique case (st_q.state)
      SVC_IDLE: begin
        if (wr && wdata == WPT_SVC_ARM) begin
          st_d.state = SVC_ARMED;
        end
      end
      SVC_ARMED: begin
        if (wr && wdata == WPT_SVC_FIRE) begin
          done       = 1'b1;
          st_d.state = SVC_IDLE;
        end
      end
      default: begin
        st_d.state = SVC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q.state <= SVC_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

endmodule

// [hdl/wpt_top.sv]
/*
  software watchdog and periodic interrupt timer with register port.
  assumes a single 100 MHz clock, ref_tick a one-cycle pulse per reference
  clock period on that clock, and clock_mode_pin / freeze_in from outside.
*/
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
module wpt_top (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [7:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  input  wire logic        clock_mode_pin,
  input  wire logic        freeze_in,
  input  wire logic        ref_tick,
  input  wire logic [2:0]  ext_irq_level,
  input  wire logic        iack,
  input  wire logic [2:0]  iack_level,
  output logic      [2:0]  irq_level,
  output logic             irq_is_periodic,
  output logic      [7:0]  iack_vector,
  output logic             iack_vector_valid,
  output logic             wd_reset_req
);
  import wpt_pkg::*;

  typedef struct packed {
    logic        pin_s1;
    logic        pin_s2;
    logic        frz_s1;
    logic        frz_s2;
    logic [1:0]  strap_cnt;
    logic        frz_bit;
    logic        wd_en;
    logic        wd_pre;
    logic [1:0]  wd_tim;
    logic        wd_locked;
    logic        act_pre;
    logic [1:0]  act_tim;
    logic [15:0] wd_cnt;
    logic        wd_rst;
    logic [2:0]  pit_lvl;
    logic [7:0]  periodic_vector;
    logic        pit_pre;
    logic [7:0]  pit_mod;
    logic [7:0]  pit_cnt;
    logic [1:0]  ref_div;
    logic        pend;
    logic [7:0]  vec;
    logic        vec_vld;
    logic [15:0] rdata;
  } wpt_main_st_t;

  wpt_main_st_t st_q;
  wpt_main_st_t st_d;

  logic halt;
  logic wd_tick_raw;
  logic wd_tick;
  logic pit_tick_raw;
  logic pit_tick;
  logic svc_done;
  logic pit_event;
  logic claim;
  logic [2:0] pit_req;

  // ==========================================================================
  // helpers
  function automatic logic [15:0] wd_last(input logic [1:0] tim);
    logic [4:0] e;
    e = 5'(WPT_WD_EXP_MIN) + 5'({tim, 1'b0});
    wd_last = (16'h0001 << e) - 16'h0001;
  endfunction

  function automatic logic [2:0] max_level(input logic [2:0] a, input logic [2:0] b);
    max_level = (a >= b) ? a : b;
  endfunction

  // ==========================================================================
  // prescalers and service detector
  wpt_div512 u_wd_pre (
    .clock    (clock),
    .rst_n    (rst_n),
    .tick_in  (wd_tick_raw),
    .bypass   (!st_q.act_pre),
    .tick_out (wd_tick)
  );

  wpt_div512 u_pit_pre (
    .clock    (clock),
    .rst_n    (rst_n),
    .tick_in  (pit_tick_raw),
    .bypass   (!st_q.pit_pre),
    .tick_out (pit_tick)
  );

  wpt_svc_seq u_svc (
    .clock (clock),
    .rst_n (rst_n),
    .wr    (wr && addr == WPT_OFF_SVC),
    .wdata (wdata[7:0]),
    .done  (svc_done)
  );

  // ==========================================================================
  // combinational terms
  assign halt         = st_q.frz_bit & st_q.frz_s2;
  assign wd_tick_raw  = st_q.wd_en & !halt;
  // four reference periods per base tick; keeps running at level zero
  assign pit_tick_raw = ref_tick & !halt & (st_q.ref_div == 2'(WPT_REF_DIV - 1));
  assign pit_event    = pit_tick & (st_q.pit_mod != 8'h00) & (st_q.pit_cnt <= 8'h01);
  assign pit_req      = st_q.pend ? st_q.pit_lvl : 3'h0;
  assign claim        = iack & st_q.pend & (iack_level == st_q.pit_lvl);

  assign irq_level         = max_level(pit_req, ext_irq_level);
  assign irq_is_periodic   = st_q.pend & (pit_req >= ext_irq_level);
  assign iack_vector       = st_q.vec;
  assign iack_vector_valid = st_q.vec_vld;
  assign wd_reset_req      = st_q.wd_rst;
  assign rdata             = st_q.rdata;

  // ==========================================================================
  // next state
  always_comb begin
    st_d         = st_q;
    st_d.pin_s1  = clock_mode_pin;
    st_d.pin_s2  = st_q.pin_s1;
    st_d.frz_s1  = freeze_in;
    st_d.frz_s2  = st_q.frz_s1;
    st_d.wd_rst  = 1'b0;
    st_d.vec_vld = 1'b0;
    st_d.rdata   = 16'h0000;

    // strap capture once the pin has crossed both flops
    if (st_q.strap_cnt != 2'h3) begin
      st_d.strap_cnt = st_q.strap_cnt + 2'h1;
    end
    if (st_q.strap_cnt == WPT_STRAP_AT) begin
      st_d.pit_pre = !st_q.pin_s2;
      if (!st_q.wd_locked) begin
        st_d.wd_pre  = !st_q.pin_s2;
        st_d.act_pre = !st_q.pin_s2;
      end
    end

    // register writes
    if (wr) begin
      unique case (addr)
        WPT_OFF_CONFIG: st_d.frz_bit = wdata[WPT_CFG_FREEZE_BIT];
        WPT_OFF_PROT: begin
          if (!st_q.wd_locked) begin
            st_d.wd_en     = wdata[WPT_PROT_EN_BIT];
            st_d.wd_pre    = wdata[WPT_PROT_PRE_BIT];
            st_d.wd_tim    = wdata[WPT_PROT_TIM_LSB +: 2];
            st_d.wd_locked = 1'b1;
          end
        end
        WPT_OFF_PCTRL: begin
          st_d.pit_lvl = wdata[WPT_PCTRL_LVL_LSB +: 3];
          st_d.periodic_vector     = wdata[7:0];
        end
        WPT_OFF_PMOD: begin
          st_d.pit_pre = wdata[WPT_PMOD_PRE_BIT];
          st_d.pit_mod = wdata[7:0];
          st_d.pit_cnt = wdata[7:0];
        end
        default: ;
      endcase
    end

    // register reads, answered next cycle
    if (rd) begin
      unique case (addr)
        WPT_OFF_CONFIG: st_d.rdata[WPT_CFG_FREEZE_BIT] = st_q.frz_bit;
        WPT_OFF_PROT: begin
          st_d.rdata[WPT_PROT_EN_BIT]       = st_q.wd_en;
          st_d.rdata[WPT_PROT_PRE_BIT]      = st_q.wd_pre;
          st_d.rdata[WPT_PROT_TIM_LSB +: 2] = st_q.wd_tim;
        end
        WPT_OFF_PCTRL: st_d.rdata = {5'h00, st_q.pit_lvl, st_q.periodic_vector};
        WPT_OFF_PMOD:  st_d.rdata = {7'h00, st_q.pit_pre, st_q.pit_mod};
        default:       st_d.rdata = 16'h0000;
      endcase
    end

    // watchdog: the active copy follows the fields on service; the strap capture also loads act_pre
    if (svc_done) begin
      st_d.wd_cnt  = 16'h0000;
      st_d.act_tim = st_q.wd_tim;
      st_d.act_pre = st_q.wd_pre;
    end else if (wd_tick) begin
      if (st_q.wd_cnt == wd_last(st_q.act_tim)) begin
        st_d.wd_rst = 1'b1;
        st_d.wd_cnt = 16'h0000;
      end else begin
        st_d.wd_cnt = st_q.wd_cnt + 16'h0001;
      end
    end

    // periodic timer
    if (ref_tick && !halt) begin
      st_d.ref_div = st_q.ref_div + 2'h1;
    end
    if (pit_tick && st_q.pit_mod != 8'h00 && !(wr && addr == WPT_OFF_PMOD)) begin
      st_d.pit_cnt = pit_event ? st_q.pit_mod : st_q.pit_cnt - 8'h01;
    end

    // request pending: a new event beats a same-cycle acknowledge
    if (claim) begin
      st_d.pend    = 1'b0;
      st_d.vec     = st_q.periodic_vector;
      st_d.vec_vld = 1'b1;
    end
    if (pit_event && st_q.pit_lvl != 3'h0) begin
      st_d.pend = 1'b1;
    end
    if (st_q.pit_lvl == 3'h0 && !(pit_event && st_d.pit_lvl != 3'h0)) begin
      st_d.pend = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q         <= '0;
      st_q.wd_en   <= WPT_RST_WD_EN;
      st_q.wd_tim  <= WPT_RST_WD_TIM;
      st_q.act_tim <= WPT_RST_WD_TIM;
      st_q.pit_lvl <= WPT_RST_LVL;
      st_q.periodic_vector     <= WPT_RST_VECTOR;
      st_q.pit_mod <= WPT_RST_MOD;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_wd_disabled_quiet: assert property (!st_q.wd_en |=> !wd_reset_req)
    else $error("watchdog reset while disabled");
  a_wd_timeout_fires: assert property (
    wd_tick && !svc_done && st_q.wd_cnt == wd_last(st_q.act_tim)
    |=> wd_reset_req ##1 !wd_reset_req)
    else $error("watchdog time-out not signalled");
  a_svc_reads_zero: assert property (rd && addr == WPT_OFF_SVC |=> rdata == 16'h0000)
    else $error("service register read not zero");
  a_tim_held_until_svc: assert property (
    !svc_done |=> st_q.act_tim == $past(st_q.act_tim))
    else $error("active timing changed without service");
  a_strap_inverted: assert property (
    st_q.strap_cnt == WPT_STRAP_AT && !st_q.wd_locked && !wr
    |=> st_q.wd_pre == !$past(st_q.pin_s2))
    else $error("prescale strap wrong");
  a_prot_write_once: assert property (
    st_q.wd_locked && st_q.strap_cnt == 2'h3 |=> $stable({st_q.wd_en, st_q.wd_pre, st_q.wd_tim}))
    else $error("protection register changed twice");
  a_freeze_stops: assert property (halt |=> $stable(st_q.wd_cnt) || $past(svc_done))
    else $error("watchdog counted while frozen");
  a_zero_mod_stops: assert property (
    st_q.pit_mod == 8'h00 && !wr |=> $stable(st_q.pit_cnt) && !$rose(st_q.pend))
    else $error("periodic timer ran with zero modulus");
  a_pit_counts_on: assert property (
    pit_tick && st_q.pit_lvl == 3'h0 && st_q.pit_cnt > 8'h01 && !wr
    |=> st_q.pit_cnt == $past(st_q.pit_cnt) - 8'h01)
    else $error("periodic counter stalled");
  a_ack_vector: assert property (
    claim |=> iack_vector_valid && iack_vector == $past(st_q.periodic_vector))
    else $error("periodic vector not returned");
  a_periodic_control_register_upper_zero: assert property (
    rd && addr == WPT_OFF_PCTRL |=> rdata[15:11] == 5'h00)
    else $error("periodic control upper bits not zero");
  a_pend_held: assert property (
    st_q.pend && !claim && st_q.pit_lvl != 3'h0 && !wr |=> st_q.pend)
    else $error("periodic request dropped");
  a_pit_reload: assert property (
    pit_event && !wr |=> st_q.pit_cnt == $past(st_q.pit_mod))
    else $error("periodic counter not reloaded");
  a_svc_restarts: assert property (svc_done |=> st_q.wd_cnt == 16'h0000)
    else $error("service did not restart watchdog");

  c_wd_timeout: cover property (wd_reset_req);
  c_pit_ack: cover property (claim);
  c_service: cover property (svc_done ##1 wd_tick);
  c_quiet_count: cover property (pit_tick && st_q.pit_lvl == 3'h0 && st_q.pit_mod != 8'h00);

endmodule

// [tb/wpt_cpu_model.sv]
/*
  behavioural processor core: register port master and interrupt acknowledge.
  assumes the block samples strobes on the rising edge of clock.
*/
`timescale 1ns/1ps
module wpt_cpu_model (
  input  wire logic        clock,
  output logic      [7:0]  addr,
  output logic      [15:0] wdata,
  output logic             wr,
  output logic             rd,
  input  wire logic [15:0] rdata,
  output logic             iack,
  output logic      [2:0]  iack_level,
  input  wire logic [7:0]  iack_vector,
  input  wire logic        iack_vector_valid
);
  import wpt_pkg::*;

  initial begin
    addr       = 8'h00;
    wdata      = 16'h0000;
    wr         = 1'b0;
    rd         = 1'b0;
    iack       = 1'b0;
    iack_level = 3'h0;
  end

  // ==========================================================================
  // bus cycles
  // released lines are inverted so a stale value is never mistaken for data
  task automatic bus_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr    <= 1'b0;
    addr  <= ~a;
    wdata <= ~d;
  endtask

  task automatic bus_rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd   <= 1'b0;
    addr <= ~a;
    #1 d = rdata;
  endtask

  task automatic svc();
    bus_wr(WPT_OFF_SVC, {8'h00, WPT_SVC_ARM});
    bus_wr(WPT_OFF_SVC, {8'h00, WPT_SVC_FIRE});
  endtask

  task automatic ack(input logic [2:0] l, output logic [7:0] v, output logic ok);
    @(posedge clock);
    iack       <= 1'b1;
    iack_level <= l;
    @(posedge clock);
    iack       <= 1'b0;
    iack_level <= ~l;
    #1 v = iack_vector;
    ok = iack_vector_valid;
  endtask
endmodule

// [tb/tb_wpt_top.sv]
/*
  self-checking bench for the watchdog / periodic timer block.
  assumes a reference tick every second clock and one clock domain.
*/
`timescale 1ns/1ps
module tb_wpt_top;
  import wpt_pkg::*;

  logic        clock          = 1'b0;
  logic        rst_n          = 1'b0;
  logic        clock_mode_pin = 1'b1;
  logic        freeze_in      = 1'b0;
  logic        ref_tick       = 1'b0;
  logic [2:0]  ext_irq_level  = 3'h0;
  logic [7:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic        iack;
  logic [2:0]  iack_level;
  logic [2:0]  irq_level;
  logic        irq_is_periodic;
  logic [7:0]  iack_vector;
  logic        iack_vector_valid;
  logic        wd_reset_req;
  int          cyc            = 0;
  int          checks         = 0;
  int          miscompares    = 0;

  always #5 clock = ~clock;
  always @(posedge clock) ref_tick <= ~ref_tick;

  wpt_top u_wpt_top (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .clock_mode_pin(clock_mode_pin), .freeze_in(freeze_in),
    .ref_tick(ref_tick), .ext_irq_level(ext_irq_level), .iack(iack), .iack_level(iack_level),
    .irq_level(irq_level), .irq_is_periodic(irq_is_periodic), .iack_vector(iack_vector),
    .iack_vector_valid(iack_vector_valid), .wd_reset_req(wd_reset_req));

  wpt_cpu_model u_wpt_cpu_model (.clock(clock), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .iack(iack), .iack_level(iack_level),
    .iack_vector(iack_vector), .iack_vector_valid(iack_vector_valid));

  // ==========================================================================
  // helpers
  task automatic summarize();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // the whole run needs about 20k cycles; twice that means a hang
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc >= 40000) begin
      miscompares++;
      summarize();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // the service write lands on a known edge, so time-outs are exact
  task automatic chk_near(input int n, input int e);
    chk(n, e);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] d;
    u_wpt_cpu_model.bus_rd(a, d);
    chk(d, e);
  endtask

  task automatic do_reset(input logic pin);
    rst_n          <= 1'b0;
    clock_mode_pin <= pin;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    repeat (5) @(posedge clock);
  endtask

  task automatic wait_wd(input int lim, output int n);
    @(posedge clock);
    #1 n = 1;
    while (wd_reset_req !== 1'b1 && n < lim) begin
      @(posedge clock);
      #1 n++;
    end
  endtask

  task automatic wait_irq(input int lim, output int n);
    // step off the edge so the request flag is settled when first looked at
    #1;
    n = 0;
    while (irq_is_periodic !== 1'b1 && n < lim) begin
      @(posedge clock);
      #1 n++;
    end
  endtask

  task automatic pit_gap(input logic [2:0] l, input logic [7:0] vec, output int t);
    int n;
    logic [7:0] v;
    logic ok;
    wait_irq(9000, n);
    t = cyc;
    chk(irq_level, l);
    u_wpt_cpu_model.ack(l, v, ok);
    chk({ok, v}, {1'b1, vec});
    wait_irq(9000, n);
    t = cyc - t;
    u_wpt_cpu_model.ack(l, v, ok);
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_regs();
    rd_chk(WPT_OFF_CONFIG, 16'h0000);
    rd_chk(WPT_OFF_PROT, 16'h0080);
    rd_chk(WPT_OFF_PCTRL, 16'h000f);
    rd_chk(WPT_OFF_PMOD, 16'h0000);
    u_wpt_cpu_model.bus_wr(WPT_OFF_SVC, 16'h0055);
    rd_chk(WPT_OFF_SVC, 16'h0000);
    rd_chk(8'h30, 16'h0000);
    u_wpt_cpu_model.bus_wr(WPT_OFF_PCTRL, 16'hffff);
    rd_chk(WPT_OFF_PCTRL, 16'h07ff);
    u_wpt_cpu_model.bus_wr(WPT_OFF_PCTRL, 16'h000f);
  endtask

  task automatic t_watchdog();
    int n;
    u_wpt_cpu_model.svc();
    wait_wd(3000, n);
    chk_near(n, 1 << WPT_WD_EXP_MIN);
    u_wpt_cpu_model.svc();
    repeat (300) @(posedge clock);
    u_wpt_cpu_model.bus_wr(WPT_OFF_SVC, 16'h00aa);
    wait_wd(3000, n);
    chk(n < 300, 1'b1);
    u_wpt_cpu_model.bus_wr(WPT_OFF_SVC, 16'h0055);
    u_wpt_cpu_model.bus_wr(WPT_OFF_SVC, 16'h0012);
    u_wpt_cpu_model.bus_wr(WPT_OFF_SVC, 16'h00aa);
    wait_wd(3000, n);
    chk_near(n, 512);
    u_wpt_cpu_model.bus_wr(WPT_OFF_PROT, 16'h0090);
    wait_wd(3000, n);
    wait_wd(3000, n);
    chk(n, 512);
    u_wpt_cpu_model.svc();
    wait_wd(3000, n);
    chk_near(n, 1 << (WPT_WD_EXP_MIN + WPT_WD_EXP_STP));
    u_wpt_cpu_model.bus_wr(WPT_OFF_PROT, 16'h0000);
    rd_chk(WPT_OFF_PROT, 16'h0090);
  endtask

  task automatic t_strap();
    int n;
    do_reset(1'b0);
    rd_chk(WPT_OFF_PROT, 16'h00c0);
    rd_chk(WPT_OFF_PMOD, 16'h0100);
    u_wpt_cpu_model.bus_wr(WPT_OFF_PROT, 16'h0040);
    wait_wd(3000, n);
    chk(n, 3000);
    do_reset(1'b1);
  endtask

  task automatic t_periodic();
    int t;
    int n;
    logic [7:0] v;
    logic ok;
    u_wpt_cpu_model.bus_wr(WPT_OFF_PMOD, 16'h0005);
    wait_irq(300, n);
    chk(n, 300);
    for (int l = 1; l < 8; l++) begin
      ext_irq_level <= 3'(l);
      u_wpt_cpu_model.bus_wr(WPT_OFF_PCTRL, {5'h00, 3'(l), 8'h40 + 8'(l)});
      pit_gap(3'(l), 8'h40 + 8'(l), t);
      chk(t, 5 * WPT_REF_DIV * 2);
    end
    u_wpt_cpu_model.bus_wr(WPT_OFF_PMOD, 16'h0101);
    pit_gap(3'h7, 8'h47, t);
    chk(t, WPT_PRESCALE * WPT_REF_DIV * 2);
    u_wpt_cpu_model.bus_wr(WPT_OFF_CONFIG, 16'h4000);
    freeze_in <= 1'b1;
    u_wpt_cpu_model.bus_wr(WPT_OFF_PMOD, 16'h0005);
    wait_irq(300, n);
    chk(n, 300);
    freeze_in <= 1'b0;
    wait_irq(300, n);
    chk(n < 300, 1'b1);
    u_wpt_cpu_model.ack(3'h7, v, ok);
    u_wpt_cpu_model.bus_wr(WPT_OFF_PMOD, 16'h0000);
    wait_irq(300, n);
    chk(n, 300);
  endtask

  initial begin
    do_reset(1'b1);
    t_regs();
    t_watchdog();
    t_strap();
    t_periodic();
    summarize();
  end
endmodule
